// ===== shared/pbc_pkg.sv
// pbc_pkg: offsets, field layout, reset values and helpers of the power budget block
`default_nettype none
package pbc_pkg;

  // ------------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------------
  localparam int PBC_AW = 12;
  localparam int PBC_DW = 32;
  localparam int PBC_SW = PBC_DW / 8;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [PBC_AW-1:0] PBC_OFF_HEADER = 12'h280;
  localparam logic [PBC_AW-1:0] PBC_OFF_SELECT = 12'h284;
  localparam logic [PBC_AW-1:0] PBC_OFF_DATA = 12'h288;
  localparam logic [PBC_AW-1:0] PBC_OFF_ALLOC = 12'h28c;
  localparam logic [PBC_AW-1:0] PBC_OFF_VALUE_BASE = 12'h300;
  localparam logic [PBC_AW-1:0] PBC_OFF_SWITCH_CONTROL_REG = 12'h404;

  // ------------------------------------------------------------------
  // budget value array
  // ------------------------------------------------------------------
  localparam int PBC_NUM_VALUES = 8;
  localparam int PBC_IDX_W = 3;
  localparam int PBC_WORD_LSB = 2;

  // ------------------------------------------------------------------
  // field positions and widths
  // ------------------------------------------------------------------
  localparam int PBC_CAPABILITY_IDENTIFIER_LSB = 0;
  localparam int PBC_CAPABILITY_IDENTIFIER_W = 16;
  localparam int PBC_CAPABILITY_VERSION_LSB = 16;
  localparam int PBC_CAPABILITY_VERSION_W = 4;
  localparam int PBC_NEXT_CAPABILITY_POINTER_LSB = 20;
  localparam int PBC_NEXT_CAPABILITY_POINTER_W = 12;
  localparam int PBC_SEL_LSB = 0;
  localparam int PBC_SEL_W = 8;
  localparam int PBC_SA_BIT = 0;
  localparam int PBC_UNLOCK_BIT = 0;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [PBC_CAPABILITY_IDENTIFIER_W-1:0] PBC_CAPABILITY_IDENTIFIER_RST = 16'h0000;
  localparam logic [PBC_CAPABILITY_VERSION_W-1:0] PBC_CAPABILITY_VERSION_RST = 4'h0;
  localparam logic [PBC_NEXT_CAPABILITY_POINTER_W-1:0] PBC_NEXT_CAPABILITY_POINTER_RST = 12'h000;
  localparam logic [PBC_SEL_W-1:0] PBC_SEL_RST = 8'h00;
  localparam logic PBC_SA_RST = 1'b0;
  localparam logic PBC_UNLOCK_RST = 1'b0;
  localparam logic [PBC_DW-1:0] PBC_VALUE_RST = 32'h0000_0000;

  // byte-lane merge of a write into an existing word
  function automatic logic [PBC_DW-1:0] pbc_merge(
    input logic [PBC_DW-1:0] old_word,
    input logic [PBC_DW-1:0] new_word,
    input logic [PBC_SW-1:0] strb
  );
    logic [PBC_DW-1:0] res;
    res = old_word;
    for (int i = 0; i < PBC_SW; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage
`default_nettype wire

// ===== design/pbc_apb_port.sv
// pbc_apb_port: zero-wait apb slave handshake with registered read answer
`timescale 1ns/100ps
`default_nettype none
module pbc_apb_port (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // slave select
  input wire logic penable, // access phase
  input wire logic pwrite, // direction, high for write
  input wire logic addr_hit, // address maps to a register
  input wire logic [pbc_pkg::PBC_DW-1:0] rd_value, // decoded read word
  output logic wr_commit, // write takes effect this edge
  output logic [pbc_pkg::PBC_DW-1:0] prdata, // read data
  output logic pready, // transfer complete
  output logic pslverr // unmapped address
);
  import pbc_pkg::*;

  logic setup;
  logic [PBC_DW-1:0] prdata_r;
  logic pslverr_r;

  // ------------------------------------------------------------------
  // phase decode
  // ------------------------------------------------------------------
  // every access completes in its first access cycle
  assign setup = psel & ~penable;
  assign pready = 1'b1;
  assign wr_commit = psel & penable & pwrite & ~pslverr_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  // answer is captured at setup so the access phase shows it from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= (!pwrite && addr_hit) ? rd_value : '0;
      pslverr_r <= ~addr_hit;
    end
  end

endmodule
`default_nettype wire

// ===== design/pbc_value_bank.sv
// pbc_value_bank: sticky array of budget value words
`timescale 1ns/100ps
`default_nettype none
module pbc_value_bank #(
  parameter int NUM = pbc_pkg::PBC_NUM_VALUES // number of words
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // fundamental reset, active low
  input wire logic wr_en, // write strobe, already gated by unlock
  input wire logic [pbc_pkg::PBC_IDX_W-1:0] wr_idx, // word written
  input wire logic [pbc_pkg::PBC_DW-1:0] wr_data, // write data
  input wire logic [pbc_pkg::PBC_SW-1:0] wr_strb, // byte enables
  input wire logic [pbc_pkg::PBC_IDX_W-1:0] rd_idx, // word read
  output logic [pbc_pkg::PBC_DW-1:0] rd_data // selected word
);
  import pbc_pkg::*;

  logic [PBC_DW-1:0] mem_r [NUM];

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  // only the fundamental reset reaches these words; hot reset does not
  for (genvar g = 0; g < NUM; g++) begin : g_word
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mem_r[g] <= PBC_VALUE_RST;
      end else if (wr_en && (wr_idx == PBC_IDX_W'(g))) begin
        mem_r[g] <= pbc_merge(mem_r[g], wr_data, wr_strb); // R08
      end
    end
  end

  assign rd_data = mem_r[rd_idx];

endmodule
`default_nettype wire

// ===== design/pbc_top.sv
// pbc_top: power budgeting capability register block behind an apb slave
`timescale 1ns/100ps
`default_nettype none
// Operation
// R01 - Header id field, 16 bits, resets to zero; four marks budgeting.
// R02 - Header version field, 4 bits, resets to zero; one means version one.
// R03 - The 8-bit read-write value select resets to zero and picks a value.
// R04 - A value select above seven makes the data register read zero.
// R05 - The read-only data register shows the selected value, else zero.
// R06 - Allocation bit zero is the system-allocated flag, reset to zero.
// R07 - Eight sticky 32-bit budget value registers start at offset 0x300.
// R08 - Budget values are readable and writable while value unlock is set.
// R09 - While value unlock is clear, writes to budget values are discarded.
// R10 - An eeprom loader is expected to preload id, version, flag and values.
// R11 - A hot reset leaves the sticky budget values unchanged.
// R12 - Reserved select and allocation bits read zero and ignore writes.
module pbc_top (
  input wire logic pclk, // bus clock, 100 MHz
  input wire logic presetn, // fundamental reset, async, active low
  input wire logic hot_reset, // hot reset level, synchronous
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [pbc_pkg::PBC_AW-1:0] paddr, // apb byte address
  input wire logic [pbc_pkg::PBC_DW-1:0] pwdata, // apb write data
  input wire logic [pbc_pkg::PBC_SW-1:0] pstrb, // apb byte strobes
  output logic [pbc_pkg::PBC_DW-1:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  output logic system_allocated, // allocation flag to the system
  output logic value_unlock // budget values writable
);
  import pbc_pkg::*;

  // ------------------------------------------------------------------
  // register state
  // ------------------------------------------------------------------
  logic [PBC_CAPABILITY_IDENTIFIER_W-1:0] capability_identifier_r;
  logic [PBC_CAPABILITY_VERSION_W-1:0] capability_version_r;
  logic [PBC_NEXT_CAPABILITY_POINTER_W-1:0] next_capability_pointer_r;
  logic [PBC_SEL_W-1:0] value_select_r;
  logic system_allocated_r;
  logic value_unlock_r;

  logic [PBC_CAPABILITY_IDENTIFIER_W-1:0] capability_identifier_nxt;
  logic [PBC_CAPABILITY_VERSION_W-1:0] capability_version_nxt;
  logic [PBC_NEXT_CAPABILITY_POINTER_W-1:0] next_capability_pointer_nxt;
  logic [PBC_SEL_W-1:0] value_select_nxt;
  logic system_allocated_nxt;
  logic value_unlock_nxt;

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  logic wr_commit;
  logic hit_header;
  logic hit_select;
  logic hit_data;
  logic hit_alloc;
  logic hit_value;
  logic hit_switch_control_reg;
  logic addr_hit;
  logic [PBC_IDX_W-1:0] addr_idx;
  logic [PBC_AW-1:0] value_span;

  // the value window covers eight aligned words from its base
  assign value_span = paddr - PBC_OFF_VALUE_BASE;
  assign addr_idx = value_span[PBC_WORD_LSB +: PBC_IDX_W];
  assign hit_header = (paddr == PBC_OFF_HEADER);
  assign hit_select = (paddr == PBC_OFF_SELECT);
  assign hit_data = (paddr == PBC_OFF_DATA);
  assign hit_alloc = (paddr == PBC_OFF_ALLOC);
  assign hit_value = (paddr >= PBC_OFF_VALUE_BASE) &&
    (value_span < PBC_AW'(PBC_NUM_VALUES * 4)) &&
    (paddr[PBC_WORD_LSB-1:0] == '0); // R07
  assign hit_switch_control_reg = (paddr == PBC_OFF_SWITCH_CONTROL_REG);
  assign addr_hit = hit_header | hit_select | hit_data | hit_alloc |
    hit_value | hit_switch_control_reg;

  // ------------------------------------------------------------------
  // word images as software sees them
  // ------------------------------------------------------------------
  logic [PBC_DW-1:0] header_word;
  logic [PBC_DW-1:0] select_word;
  logic [PBC_DW-1:0] alloc_word;
  logic [PBC_DW-1:0] switch_control_reg_word;

  assign header_word = {next_capability_pointer_r, capability_version_r,
    capability_identifier_r}; // R01 R02
  // reserved bits above the live fields are driven as zero
  assign select_word = PBC_DW'(value_select_r); // R12
  assign alloc_word = PBC_DW'(system_allocated_r) << PBC_SA_BIT; // R12
  assign switch_control_reg_word = PBC_DW'(value_unlock_r) << PBC_UNLOCK_BIT;

  // ------------------------------------------------------------------
  // budget value bank and data register view
  // ------------------------------------------------------------------
  logic select_in_range;
  logic [PBC_IDX_W-1:0] select_idx;
  logic [PBC_IDX_W-1:0] bank_rd_idx;
  logic [PBC_DW-1:0] bank_rd_data;
  logic [PBC_DW-1:0] data_word;
  logic value_wr_en;

  // the bank has one read port: direct reads of a value word take it,
  // the data register uses it otherwise; both never happen in one cycle
  assign select_in_range = (value_select_r < PBC_SEL_W'(PBC_NUM_VALUES));
  assign select_idx = value_select_r[PBC_IDX_W-1:0];
  assign bank_rd_idx = hit_value ? addr_idx : select_idx;
  assign data_word = select_in_range ? bank_rd_data : '0; // R04 R05
  // a locked bank drops the write silently, the bus sees no error
  assign value_wr_en = wr_commit & hit_value & value_unlock_r; // R08 R09

  pbc_value_bank #(
    .NUM(PBC_NUM_VALUES)
  ) u_bank (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(value_wr_en),
    .wr_idx(addr_idx),
    .wr_data(pwdata),
    .wr_strb(pstrb),
    .rd_idx(bank_rd_idx),
    .rd_data(bank_rd_data)
  );

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  logic [PBC_DW-1:0] rd_value;

  always_comb begin
    rd_value = '0;
    unique case (1'b1)
      hit_header: rd_value = header_word;
      hit_select: rd_value = select_word;
      hit_data: rd_value = data_word; // R05
      hit_alloc: rd_value = alloc_word;
      hit_value: rd_value = bank_rd_data; // R08
      hit_switch_control_reg: rd_value = switch_control_reg_word;
      default: rd_value = '0;
    endcase
  end

  pbc_apb_port u_port (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .addr_hit(addr_hit),
    .rd_value(rd_value),
    .wr_commit(wr_commit),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  // ------------------------------------------------------------------
  // next-state of the non-sticky registers
  // ------------------------------------------------------------------
  logic [PBC_DW-1:0] header_merged;
  logic [PBC_DW-1:0] select_merged;
  logic [PBC_DW-1:0] alloc_merged;
  logic [PBC_DW-1:0] switch_control_reg_merged;

  // eeprom loader and software share this path, so the header is
  // writable by any bus master; the loader is outside this block (R10)
  assign header_merged = pbc_merge(header_word, pwdata, pstrb);
  assign select_merged = pbc_merge(select_word, pwdata, pstrb);
  assign alloc_merged = pbc_merge(alloc_word, pwdata, pstrb);
  assign switch_control_reg_merged = pbc_merge(switch_control_reg_word, pwdata, pstrb);

  // hot reset returns these to reset value; bank words are not touched
  always_comb begin
    capability_identifier_nxt = capability_identifier_r;
    capability_version_nxt = capability_version_r;
    next_capability_pointer_nxt = next_capability_pointer_r;
    value_select_nxt = value_select_r;
    system_allocated_nxt = system_allocated_r;
    value_unlock_nxt = value_unlock_r;
    if (hot_reset) begin
      capability_identifier_nxt = PBC_CAPABILITY_IDENTIFIER_RST; // R01 R11
      capability_version_nxt = PBC_CAPABILITY_VERSION_RST; // R02
      next_capability_pointer_nxt = PBC_NEXT_CAPABILITY_POINTER_RST;
      value_select_nxt = PBC_SEL_RST; // R03
      system_allocated_nxt = PBC_SA_RST; // R06
      value_unlock_nxt = PBC_UNLOCK_RST;
    end else if (wr_commit) begin
      if (hit_header) begin
        capability_identifier_nxt =
          header_merged[PBC_CAPABILITY_IDENTIFIER_LSB +: PBC_CAPABILITY_IDENTIFIER_W]; // R01
        capability_version_nxt =
          header_merged[PBC_CAPABILITY_VERSION_LSB +: PBC_CAPABILITY_VERSION_W]; // R02
        next_capability_pointer_nxt =
          header_merged[PBC_NEXT_CAPABILITY_POINTER_LSB +: PBC_NEXT_CAPABILITY_POINTER_W];
      end
      if (hit_select) begin
        value_select_nxt = select_merged[PBC_SEL_LSB +: PBC_SEL_W]; // R03
      end
      if (hit_alloc) begin
        system_allocated_nxt = alloc_merged[PBC_SA_BIT]; // R06 R12
      end
      if (hit_switch_control_reg) begin
        value_unlock_nxt = switch_control_reg_merged[PBC_UNLOCK_BIT];
      end
    end
  end

  // ------------------------------------------------------------------
  // register flops
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capability_identifier_r <= PBC_CAPABILITY_IDENTIFIER_RST;
      capability_version_r <= PBC_CAPABILITY_VERSION_RST;
      next_capability_pointer_r <= PBC_NEXT_CAPABILITY_POINTER_RST;
      value_select_r <= PBC_SEL_RST;
      system_allocated_r <= PBC_SA_RST;
      value_unlock_r <= PBC_UNLOCK_RST;
    end else begin
      capability_identifier_r <= capability_identifier_nxt;
      capability_version_r <= capability_version_nxt;
      next_capability_pointer_r <= next_capability_pointer_nxt;
      value_select_r <= value_select_nxt;
      system_allocated_r <= system_allocated_nxt;
      value_unlock_r <= value_unlock_nxt;
    end
  end

  // ------------------------------------------------------------------
  // side outputs
  // ------------------------------------------------------------------
  assign system_allocated = system_allocated_r; // R06
  assign value_unlock = value_unlock_r;

endmodule
`default_nettype wire

// ===== test/pbc_top_properties.sv
// pbc_top_properties: bus-level assertions of the power budget block
`timescale 1ns/100ps
`default_nettype none
module pbc_top_properties (
  input wire logic pclk, // bus clock
  input wire logic presetn, // fundamental reset, active low
  input wire logic hot_reset, // hot reset level
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [pbc_pkg::PBC_AW-1:0] paddr, // byte address
  input wire logic [pbc_pkg::PBC_DW-1:0] pwdata, // write data
  input wire logic [pbc_pkg::PBC_SW-1:0] pstrb, // byte strobes
  input wire logic [pbc_pkg::PBC_DW-1:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic system_allocated, // allocation flag
  input wire logic value_unlock // budget values writable
);
  import pbc_pkg::*;
  // ------------------------------------------------------------------
  // shadow state rebuilt from completed bus writes
  // ------------------------------------------------------------------
  logic [PBC_DW-1:0] hdr_r;
  logic [PBC_SEL_W-1:0] sel_r;
  logic [PBC_DW-1:0] bank_r [PBC_NUM_VALUES];
  // decode of the access phase; pready is always high in this block
  wire logic wr_c = psel && penable && pwrite;
  wire logic rd_c = psel && penable && !pwrite;
  wire logic in_bank = paddr[11:5] == 7'h18 && paddr[1:0] == 2'h0;
  wire logic [PBC_DW-1:0] pick = bank_r[sel_r[2:0]];
  wire logic [PBC_DW-1:0] word = bank_r[paddr[4:2]];
  wire logic wbit = pwdata[0];

  // byte-lane merge kept local so the check does not lean on design code
  function automatic logic [PBC_DW-1:0] lanes(input logic [PBC_DW-1:0] o,
    input logic [PBC_DW-1:0] n, input logic [PBC_SW-1:0] s);
    for (int i = 0; i < PBC_SW; i++) begin
      if (s[i]) begin
        o[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return o;
  endfunction

  // budget words survive hot reset, header and select do not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdr_r <= '0;
      sel_r <= '0;
      for (int i = 0; i < PBC_NUM_VALUES; i++) begin
        bank_r[i] <= '0;
      end
    end else begin
      if (hot_reset) begin
        hdr_r <= '0;
        sel_r <= '0;
      end else if (wr_c && paddr == PBC_OFF_HEADER) begin
        hdr_r <= lanes(hdr_r, pwdata, pstrb);
      end else if (wr_c && paddr == PBC_OFF_SELECT && pstrb[0]) begin
        sel_r <= pwdata[7:0];
      end
      if (wr_c && in_bank && value_unlock) begin
        bank_r[paddr[4:2]] <= lanes(word, pwdata, pstrb);
      end
    end
  end

  // ------------------------------------------------------------------
  // assertions; read data was captured in the setup cycle, hence $past
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_HDR_READ: assert property (
    rd_c && paddr == PBC_OFF_HEADER |-> prdata == $past(hdr_r))
    else $error("header read differs from written value");
  AST_SEL_READ: assert property (
    rd_c && paddr == PBC_OFF_SELECT |-> prdata == {24'h0, $past(sel_r)})
    else $error("select read differs from written value");
  AST_DATA_ZERO: assert property (
    rd_c && paddr == PBC_OFF_DATA && $past(sel_r) > 8'h07 |-> prdata == 32'h0)
    else $error("data read not zero for select above seven");
  AST_DATA_PICK: assert property (
    rd_c && paddr == PBC_OFF_DATA && $past(sel_r) < 8'h08
      |-> prdata == $past(pick))
    else $error("data read does not show the selected word");
  AST_ALLOC_READ: assert property (
    rd_c && paddr == PBC_OFF_ALLOC |-> prdata == {31'h0, system_allocated})
    else $error("allocation read differs from flag");
  AST_ALLOC_SET: assert property (
    wr_c && paddr == PBC_OFF_ALLOC && pstrb[0] && !hot_reset
      |=> system_allocated == $past(wbit))
    else $error("allocation flag did not take the written bit");
  AST_VALUE_READ: assert property (
    rd_c && in_bank |-> prdata == $past(word))
    else $error("budget word read differs from expected");
  AST_HOT_CLEAR: assert property (
    hot_reset |=> !value_unlock && !system_allocated)
    else $error("hot reset left a non-sticky flag set");
endmodule

bind pbc_top pbc_top_properties i_props (.pclk(pclk), .presetn(presetn),
  .hot_reset(hot_reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .system_allocated(system_allocated),
  .value_unlock(value_unlock));
`default_nettype wire

// ===== test/pbc_top_test.sv
// pbc_top_test: self-checking apb bench of the power budget block
`timescale 1ns/100ps
`default_nettype none
module pbc_top_test;
  import pbc_pkg::*;
  typedef struct {
    string name;
    logic [PBC_DW-1:0] data;
    logic err;
    logic is_rd;
  } pbc_note_t;
  logic pclk, pready, pslverr, system_allocated, value_unlock;
  logic presetn = 1'b0;
  logic hot_reset = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [PBC_AW-1:0] paddr = '0;
  logic [PBC_DW-1:0] pwdata = '0;
  logic [PBC_SW-1:0] pstrb = '0;
  logic [PBC_DW-1:0] prdata, d;
  logic [PBC_DW-1:0] vals [PBC_NUM_VALUES];
  logic [7:0] big [4] = '{8'h08, 8'h1f, 8'h20, 8'hff};
  logic [PBC_AW-1:0] bad [4] = '{12'h290, 12'h302, 12'h320, 12'h400};
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  pbc_note_t notes[$];

  pbc_top i_dut (.pclk(pclk), .presetn(presetn), .hot_reset(hot_reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .system_allocated(system_allocated),
    .value_unlock(value_unlock));

  // ------------------------------------------------------------------
  // clock, timeout and shared tasks
  // ------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      $display("[ERR] run expected end seen timeout");
      stop_test();
    end
  end

  task automatic check(input string name, input logic [PBC_DW-1:0] seen,
    input logic [PBC_DW-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // entered just after a rising edge; no release, so calls run back to back
  // the wait has no cap of its own: only the bench timeout ends it
  task automatic apb(input logic wr, input logic [PBC_AW-1:0] a,
    input logic [PBC_DW-1:0] v, input logic [PBC_SW-1:0] s);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
  endtask

  task automatic rd(input logic [PBC_AW-1:0] a, input logic [PBC_DW-1:0] e,
    input logic err, input string name);
    notes.push_back('{name, e, err, 1'b1});
    apb(1'b0, a, $urandom, 4'h0);
  endtask

  task automatic wr(input logic [PBC_AW-1:0] a, input logic [PBC_DW-1:0] v,
    input logic [PBC_SW-1:0] s, input logic err);
    notes.push_back('{"write", '0, err, 1'b0});
    apb(1'b1, a, v, s);
  endtask

  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [PBC_AW-1:0] vaddr(input int i);
    return PBC_OFF_VALUE_BASE + PBC_AW'(i * 4);
  endfunction

  // monitor: every completed transfer retires the oldest note
  always @(posedge pclk) begin
    pbc_note_t n;
    if (presetn && psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      n = notes.pop_front();
      check({n.name, " error"}, {31'h0, pslverr}, {31'h0, n.err});
      if (n.is_rd) check(n.name, prdata, n.data);
    end
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(43));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(PBC_OFF_HEADER, 32'h0, 1'b0, "header");
    rd(PBC_OFF_SELECT, 32'h0, 1'b0, "select");
    rd(PBC_OFF_DATA, 32'h0, 1'b0, "data");
    rd(PBC_OFF_ALLOC, 32'h0, 1'b0, "alloc");
    foreach (bad[i]) rd(bad[i], 32'h0, 1'b1, "unmapped");
    wr(bad[0], $urandom, 4'hf, 1'b1);
    // preload as the eeprom loader would, then a single-lane update
    wr(PBC_OFF_HEADER, 32'h0011_0004, 4'hf, 1'b0);
    d = $urandom;
    wr(PBC_OFF_HEADER, d, 4'b0100, 1'b0);
    // lane two carries the version and the low nibble of the next pointer
    rd(PBC_OFF_HEADER, {8'h00, d[23:16], 16'h0004}, 1'b0,
      "header");
    // locked write must vanish
    wr(vaddr(0), $urandom, 4'hf, 1'b0);
    rd(vaddr(0), 32'h0, 1'b0, "locked word");
    wr(PBC_OFF_SWITCH_CONTROL_REG, 32'h1, 4'hf, 1'b0);
    idle();
    check("value_unlock", {31'h0, value_unlock}, 32'h1);
    for (int i = 0; i < PBC_NUM_VALUES; i++) begin
      vals[i] = $urandom;
      wr(vaddr(i), vals[i], 4'hf, 1'b0);
    end
    d = $urandom;
    wr(vaddr(5), d, 4'b1001, 1'b0);
    vals[5] = {d[31:24], vals[5][23:8], d[7:0]};
    for (int i = 0; i < PBC_NUM_VALUES; i++) begin
      rd(vaddr(i), vals[i], 1'b0, "budget word");
    end
    // every legal select, reserved bits written as noise
    for (int i = 0; i < PBC_NUM_VALUES; i++) begin
      d = $urandom;
      wr(PBC_OFF_SELECT, {d[31:8], 8'(i)}, 4'hf, 1'b0);
      rd(PBC_OFF_SELECT, 32'(i), 1'b0, "select");
      rd(PBC_OFF_DATA, vals[i], 1'b0, "data");
    end
    foreach (big[i]) begin
      wr(PBC_OFF_SELECT, {24'hffffff, big[i]}, 4'hf, 1'b0);
      rd(PBC_OFF_DATA, 32'h0, 1'b0, "data high select");
    end
    wr(PBC_OFF_SELECT, 32'h2, 4'hf, 1'b0);
    wr(PBC_OFF_DATA, $urandom, 4'hf, 1'b0);
    rd(PBC_OFF_DATA, vals[2], 1'b0, "data after write");
    wr(PBC_OFF_ALLOC, 32'hffff_ffff, 4'b1110, 1'b0);
    rd(PBC_OFF_ALLOC, 32'h0, 1'b0, "alloc");
    wr(PBC_OFF_ALLOC, 32'hffff_ffff, 4'hf, 1'b0);
    rd(PBC_OFF_ALLOC, 32'h1, 1'b0, "alloc");
    idle();
    check("system_allocated", {31'h0, system_allocated}, 32'h1);
    // relock, then a write to a word must not land
    wr(PBC_OFF_SWITCH_CONTROL_REG, 32'h0, 4'hf, 1'b0);
    wr(vaddr(3), ~vals[3], 4'hf, 1'b0);
    rd(vaddr(3), vals[3], 1'b0, "locked word");
    // hot reset clears the rest but keeps the sticky words
    wr(PBC_OFF_SWITCH_CONTROL_REG, 32'h1, 4'hf, 1'b0);
    wr(PBC_OFF_SELECT, 32'h4, 4'hf, 1'b0);
    idle();
    hot_reset <= 1'b1;
    repeat (2) @(posedge pclk);
    hot_reset <= 1'b0;
    @(posedge pclk);
    check("hot flags", {30'h0, system_allocated, value_unlock}, 32'h0);
    rd(PBC_OFF_HEADER, 32'h0, 1'b0, "header after hot");
    rd(PBC_OFF_DATA, vals[0], 1'b0, "data after hot");
    for (int i = 0; i < PBC_NUM_VALUES; i++) begin
      rd(vaddr(i), vals[i], 1'b0, "sticky word");
    end
    idle();
    // a transfer that never completed leaves its note behind
    check("notes left", 32'(notes.size()), 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
